// >>> serial_flash_pin_interface.sv
// serial flash pin front end with an AXI4-Lite control slave
// What this block does
// - select high: deselected, every data lane output released
// - select low selects; only then instruction bits in and data out
// - after reset nothing is accepted before a select high-to-low edge
// - single lane: sample serial input on each serial clock rising edge
// - single lane: launch read data on lane 1 at falling edges
// - dual and quad lanes: capture on rising, launch on falling edges
// - quad needs quad lane enable; then protect and pause pins are lanes 2, 3
// - active-low write protect with lock bits blocks status writes, protects array
// - quad lane enable disables hardware write protection
// - pause low while selected: outputs released, input and clock ignored
// - pause release continues from the state held at pause
// - quad lane enable disables the pause function
// - pages of 256 bytes; one program writes 1 to 256 bytes
// - erase units: 16, 128, 256 pages or the whole array
// - page count is a parameter: 4096, 8192 or 16384
// - a 64-bit unique serial number is readable by the host
// - only clock modes 0 and 3, clock idle at select edges
// - pause acts at its edge with clock low, else after next falling edge
// - pause applies to single and dual operation only
`timescale 1ns/1ps
`default_nettype none
module serial_flash_pin_interface #(
   parameter int unsigned PAGE_COUNT = serial_flash_pkg::PAGE_COUNT_DEF,
   // arbitrary value
   parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // flash pins
   input wire logic sck,
   input wire logic cs_b,
   input wire logic [3:0] lane_in,
   output logic [3:0] lane_out,
   output logic [3:0] lane_oe
);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] erase_pages(input logic [1:0] kind);
      unique case (kind)
         2'h0: erase_pages = 16'(serial_flash_pkg::SECTOR_PAGES);
         2'h1: erase_pages = 16'(serial_flash_pkg::SMALL_BLOCK_PAGES);
         2'h2: erase_pages = 16'(serial_flash_pkg::LARGE_BLOCK_PAGES);
         2'h3: erase_pages = 16'(PAGE_COUNT);
      endcase
   endfunction

   function automatic logic [3:0] lane_mask(input logic [2:0] w);
      unique case (w)
         3'h2: lane_mask = 4'h3;
         3'h4: lane_mask = 4'hF;
         default: lane_mask = 4'h2;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [5:0] pin_m_r;
   logic [5:0] pin_s_r;
   logic sck_d_r;
   logic cs_d_r;
   logic [13:0] ctrl_r;
   logic [7:0] txdata_r;
   logic armed_r;
   logic selected_r;
   logic paused_r;
   logic blocked_r;
   serial_flash_pkg::phase_type phase_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] rx_sh_r;
   logic [7:0] instr_r;
   logic [7:0] rx_byte_r;
   logic [15:0] rx_count_r;
   logic [8:0] prog_count_r;
   logic [7:0] tx_sh_r;
   logic [3:0] tx_left_r;
   logic [2:0] uid_idx_r;
   logic tx_started_r;
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic cs_s;
   logic sck_s;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic qe;
   logic act;
   logic pause_allowed;
   logic [2:0] width;
   logic [3:0] bit_sum;
   logic [7:0] rx_sh_nxt;
   logic [7:0] tx_cur;
   logic [7:0] tx_next_byte;
   logic wr_commit;
   logic [31:0] rd_word;
   logic rd_ok;

   ////////////////////////////////////////////////////////////////////////
   // pins cross from the host's clock domain through two flops
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_m_r <= serial_flash_pkg::PIN_RESET;
         pin_s_r <= serial_flash_pkg::PIN_RESET;
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b0;
      end else begin
         pin_m_r <= {cs_b, sck, lane_in};
         pin_s_r <= pin_m_r;
         sck_d_r <= pin_s_r[serial_flash_pkg::PIN_SCK];
         cs_d_r <= pin_s_r[serial_flash_pkg::PIN_CS];
      end
   end

   assign cs_s = pin_s_r[serial_flash_pkg::PIN_CS];
   assign sck_s = pin_s_r[serial_flash_pkg::PIN_SCK];
   // idle level is free: mode 3's leading falling edge lands in the instruction phase and is ignored
   assign sck_rise = sck_s & ~sck_d_r;
   assign sck_fall = ~sck_s & sck_d_r;
   assign cs_fall = ~cs_s & cs_d_r;
   assign qe = ctrl_r[serial_flash_pkg::QE_POS];
   assign act = selected_r & ~paused_r & ~cs_s;
   assign pause_allowed = selected_r & ~qe & ~cs_s;

   // quad falls back to one lane unless quad lanes are enabled
   always_comb begin
      width = 3'h1;
      if (phase_r == serial_flash_pkg::PH_DATA) begin
         unique case (serial_flash_pkg::lane_mode_type'(ctrl_r[serial_flash_pkg::MODE_POS +: 2]))
            serial_flash_pkg::LANE_DUAL: width = 3'h2;
            serial_flash_pkg::LANE_QUAD: width = qe ? 3'h4 : 3'h1;
            default: width = 3'h1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // selection: a fresh fall of select is needed after reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         armed_r <= 1'b0;
         selected_r <= 1'b0;
      end else begin
         if (cs_s) begin
            armed_r <= 1'b1;
         end
         if (cs_s) begin
            selected_r <= 1'b0;
         end else if (cs_fall && armed_r) begin
            selected_r <= 1'b1;
         end
      end
   end

   // pause follows the pin only while the clock is low
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         paused_r <= 1'b0;
      end else if (!pause_allowed) begin
         paused_r <= 1'b0;
      end else if (!sck_s) begin
         paused_r <= ~pin_s_r[3];
      end
   end

   // status writes locked by the protect pin unless it is lane 2
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         blocked_r <= 1'b0;
      end else begin
         blocked_r <= ctrl_r[serial_flash_pkg::LOCK_POS + 1]
            | (ctrl_r[serial_flash_pkg::LOCK_POS] & ~qe & ~pin_s_r[2]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign bit_sum = {1'b0, bit_cnt_r} + {1'b0, width};

   always_comb begin
      unique case (width)
         3'h2: rx_sh_nxt = {rx_sh_r[5:0], pin_s_r[1], pin_s_r[0]};
         3'h4: rx_sh_nxt = {rx_sh_r[3:0], pin_s_r[3:0]};
         default: rx_sh_nxt = {rx_sh_r[6:0], pin_s_r[0]};
      endcase
   end

   // capture on rising edges; bit and page counters restart when select rises, byte count on its fall
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_r <= serial_flash_pkg::PH_IDLE;
         bit_cnt_r <= 3'h0;
         rx_sh_r <= 8'h00;
         instr_r <= 8'h00;
         rx_byte_r <= 8'h00;
         rx_count_r <= 16'h0000;
         prog_count_r <= 9'h000;
      end else if (cs_s) begin
         phase_r <= serial_flash_pkg::PH_IDLE;
         bit_cnt_r <= 3'h0;
         prog_count_r <= 9'h000;
      end else if (cs_fall && armed_r) begin
         phase_r <= serial_flash_pkg::PH_INSTR;
         bit_cnt_r <= 3'h0;
         rx_count_r <= 16'h0000;
      end else if (sck_rise && act && phase_r != serial_flash_pkg::PH_IDLE) begin
         rx_sh_r <= rx_sh_nxt;
         bit_cnt_r <= bit_sum[2:0];
         if (bit_sum[3]) begin
            if (phase_r == serial_flash_pkg::PH_INSTR) begin
               instr_r <= rx_sh_nxt;
               phase_r <= serial_flash_pkg::PH_DATA;
            end else if (!ctrl_r[serial_flash_pkg::DRIVE_POS]) begin
               rx_byte_r <= rx_sh_nxt;
               rx_count_r <= rx_count_r + 16'h0001;
               if (prog_count_r != 9'(serial_flash_pkg::PAGE_BYTES)) begin
                  prog_count_r <= prog_count_r + 9'h001;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign tx_next_byte = ctrl_r[serial_flash_pkg::UIDSRC_POS]
      ? UNIQUE_ID[8 * (7 - uid_idx_r) +: 8] : txdata_r;

   always_comb begin
      if (tx_left_r == 4'h0) begin
         tx_cur = tx_next_byte;
      end else begin
         unique case (width)
            3'h2: tx_cur = {tx_sh_r[5:0], 2'h0};
            3'h4: tx_cur = {tx_sh_r[3:0], 4'h0};
            default: tx_cur = {tx_sh_r[6:0], 1'b0};
         endcase
      end
   end

   // launch on falling edges in the data phase
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_sh_r <= 8'h00;
         tx_left_r <= 4'h0;
         uid_idx_r <= 3'h0;
         tx_started_r <= 1'b0;
         lane_out <= 4'h0;
      end else if (cs_s) begin
         tx_left_r <= 4'h0;
         uid_idx_r <= 3'h0;
         tx_started_r <= 1'b0;
         lane_out <= 4'h0;
      end else if (sck_fall && act && phase_r == serial_flash_pkg::PH_DATA
                   && ctrl_r[serial_flash_pkg::DRIVE_POS]) begin
         tx_sh_r <= tx_cur;
         tx_started_r <= 1'b1;
         tx_left_r <= ((tx_left_r == 4'h0) ? 4'h8 : tx_left_r) - {1'b0, width};
         if (tx_left_r == 4'h0) begin
            uid_idx_r <= uid_idx_r + 3'h1;
         end
         unique case (width)
            3'h2: lane_out <= {2'h0, tx_cur[7:6]};
            3'h4: lane_out <= tx_cur[7:4];
            default: lane_out <= {2'h0, tx_cur[7], 1'b0};
         endcase
      end
   end

   // released while deselected or paused; mode may change lanes mid frame
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lane_oe <= 4'h0;
      end else if (act && tx_started_r && ctrl_r[serial_flash_pkg::DRIVE_POS]) begin
         lane_oe <= lane_mask(width);
      end else begin
         lane_oe <= 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write: address and data held independently
   assign wr_commit = aw_held_r & w_held_r & ~s_axi_bvalid;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= serial_flash_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_commit) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r == serial_flash_pkg::CTRL_OFS
               || aw_addr_r == serial_flash_pkg::TXDATA_OFS)
               ? serial_flash_pkg::RESP_OKAY : serial_flash_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // guarded fields keep their value while writes are blocked
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= serial_flash_pkg::CTRL_RESET;
         txdata_r <= serial_flash_pkg::TXDATA_RESET;
      end else if (wr_commit && w_strb_r[0] && aw_addr_r == serial_flash_pkg::TXDATA_OFS) begin
         txdata_r <= w_data_r[7:0];
      end else if (wr_commit && aw_addr_r == serial_flash_pkg::CTRL_OFS) begin
         for (int i = 0; i < 14; i++) begin
            if (w_strb_r[i / 8] && !(blocked_r && serial_flash_pkg::CTRL_GUARDED[i])) begin
               ctrl_r[i] <= w_data_r[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         serial_flash_pkg::CTRL_OFS: rd_word = {18'h0, ctrl_r};
         serial_flash_pkg::TXDATA_OFS: rd_word = {24'h0, txdata_r};
         serial_flash_pkg::STATUS_OFS: rd_word = {rx_byte_r, instr_r, 2'h0,
            (ctrl_r[serial_flash_pkg::MODE_POS +: 2] == 2'h3) & ~qe,
            blocked_r & (ctrl_r[serial_flash_pkg::REGION_POS +: 3] != 3'h0),
            blocked_r, paused_r, armed_r, selected_r, 8'h00};
         serial_flash_pkg::COUNT_OFS: rd_word = {7'h0, prog_count_r, rx_count_r};
         serial_flash_pkg::UID_LO_OFS: rd_word = UNIQUE_ID[31:0];
         serial_flash_pkg::UID_HI_OFS: rd_word = UNIQUE_ID[63:32];
         serial_flash_pkg::GEOM_OFS: rd_word = {erase_pages(ctrl_r[serial_flash_pkg::ERASE_POS +: 2]),
            16'(PAGE_COUNT)};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= serial_flash_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? serial_flash_pkg::RESP_OKAY : serial_flash_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   chk_deselect_release: assert property (@(posedge core_clk) disable iff (!rst_b)
      cs_s |=> lane_oe == 4'h0) else $error("lanes driven while deselected");
   chk_select_on_fall: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(selected_r) |-> $past(cs_d_r) && !$past(cs_s)) else $error("select without fall");
   chk_no_unarmed: assert property (@(posedge core_clk) disable iff (!rst_b)
      !armed_r |-> !selected_r && phase_r == serial_flash_pkg::PH_IDLE) else $error("selected before armed");
   chk_instr_shift: assert property (@(posedge core_clk) disable iff (!rst_b)
      sck_rise && act && !cs_s && phase_r == serial_flash_pkg::PH_INSTR
      |=> bit_cnt_r == 3'($past(bit_cnt_r) + 3'h1)) else $error("instruction bit missed");
   chk_launch_fall: assert property (@(posedge core_clk) disable iff (!rst_b)
      $changed(lane_out) |-> $past(sck_fall) || $past(cs_s)) else $error("launch off falling edge");
   chk_quad_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
      !qe |-> width != 3'h4) else $error("quad without enable");
   chk_wp_blocks: assert property (@(posedge core_clk) disable iff (!rst_b)
      ctrl_r[serial_flash_pkg::LOCK_POS] && !qe && !pin_s_r[2] |=> blocked_r) else $error("protect ignored");
   chk_qe_frees_wp: assert property (@(posedge core_clk) disable iff (!rst_b)
      qe && !ctrl_r[serial_flash_pkg::LOCK_POS + 1] |=> !blocked_r) else $error("protect active in quad");
   chk_pause_release: assert property (@(posedge core_clk) disable iff (!rst_b)
      paused_r |=> lane_oe == 4'h0) else $error("lanes driven in pause");
   chk_pause_freeze: assert property (@(posedge core_clk) disable iff (!rst_b)
      paused_r && !cs_s |=> $stable(bit_cnt_r) && $stable(tx_sh_r)) else $error("state moved in pause");
   chk_qe_no_pause: assert property (@(posedge core_clk) disable iff (!rst_b)
      qe |=> !paused_r) else $error("pause in quad");
   chk_page_cap: assert property (@(posedge core_clk) disable iff (!rst_b)
      prog_count_r <= 9'(serial_flash_pkg::PAGE_BYTES)) else $error("page count overrun");
   chk_pause_clock_low: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(paused_r) |-> !$past(sck_s)) else $error("pause with clock high");
   chk_cs_rise_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
      cs_s |=> bit_cnt_r == 3'h0 && phase_r == serial_flash_pkg::PH_IDLE) else $error("counters kept");
   cov_instr_done: cover property (@(posedge core_clk) disable iff (!rst_b)
      phase_r == serial_flash_pkg::PH_INSTR ##1 phase_r == serial_flash_pkg::PH_DATA);
   cov_pause: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(paused_r));
   cov_quad_out: cover property (@(posedge core_clk) disable iff (!rst_b) lane_oe == 4'hF);
endmodule // serial_flash_pin_interface
`default_nettype wire

// >>> serial_flash_pkg.sv
// constants and types shared by the serial flash pin front end
`default_nettype none
package serial_flash_pkg;
   // array geometry
   localparam int unsigned PAGE_BYTES = 256;
   localparam int unsigned SECTOR_PAGES = 16;
   localparam int unsigned SMALL_BLOCK_PAGES = 128;
   localparam int unsigned LARGE_BLOCK_PAGES = 256;
   localparam int unsigned PAGE_COUNT_DEF = 4096;
   localparam int unsigned UID_BITS = 64;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] TXDATA_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] COUNT_OFS = 8'h0C;
   localparam logic [7:0] UID_LO_OFS = 8'h10;
   localparam logic [7:0] UID_HI_OFS = 8'h14;
   localparam logic [7:0] GEOM_OFS = 8'h18;
   // control fields
   localparam int QE_POS = 0;
   localparam int MODE_POS = 1;
   localparam int UIDSRC_POS = 3;
   localparam int LOCK_POS = 4;
   localparam int TB_POS = 6;
   localparam int SEC_POS = 7;
   localparam int REGION_POS = 8;
   localparam int DRIVE_POS = 11;
   localparam int ERASE_POS = 12;
   localparam logic [13:0] CTRL_RESET = 14'h0000;
   localparam logic [7:0] TXDATA_RESET = 8'hFF;
   // status-register-like fields guarded by write protection
   localparam logic [13:0] CTRL_GUARDED = 14'h07F1;
   // pin vector positions
   localparam int PIN_SCK = 4;
   localparam int PIN_CS = 5;
   // all low: select must be seen high on the pin before its first fall counts
   localparam logic [5:0] PIN_RESET = 6'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      LANE_SINGLE = 2'h0,
      LANE_DUAL = 2'h1,
      LANE_QUAD = 2'h3
   } lane_mode_type;
   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_INSTR = 2'h1,
      PH_DATA = 2'h3
   } phase_type;
endpackage
`default_nettype wire

// >>> spi_host.sv
// spi host model driving select, clock and data lanes of the flash pins
`timescale 1ns/1ps
`default_nettype none
module spi_host (
   // pins toward the device
   output logic sck,
   output logic cs_b,
   output logic [3:0] drv,
   // resolved pin levels and device enables
   input wire logic [3:0] pin,
   input wire logic [3:0] oe,
   // write protect level set by the bench
   input wire logic wp_b
);
   logic d0;
   logic hold_b;
   // a released lane_1 shows a changing level, never the last driven bit
   assign drv = {hold_b, wp_b, ~d0, d0};
   initial begin
      sck = 0;
      cs_b = 1;
      d0 = 0;
      hold_b = 1;
   end
   task automatic frame(input logic [7:0] ins, input logic [7:0] d, input logic hold,
      output logic [7:0] rd, output logic [3:0] oe_run, output logic [3:0] oe_hold);
      int i;
      oe_hold = 4'h0;
      cs_b = 0;
      for (i = 15; i >= 0; i--) begin
         d0 = (i > 7) ? ins[i - 8] : d[i];
         #62.5 sck = 1;
         if (i < 8) rd[i] = pin[1];
         if (i == 0) oe_run = oe;
         #62.5 sck = 0;
         if (hold && i == 4) begin
            // pause with the clock low, then a clock pulse that must be ignored
            #40 hold_b = 0;
            #50 sck = 1;
            #50 sck = 0;
            #50 oe_hold = oe;
            hold_b = 1;
            #40;
         end
      end
      #62.5 cs_b = 1;
      d0 = ~d0;
      #250;
   endtask
endmodule // spi_host
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk = 0;
   logic rst_b = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, rd;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, wp_b = 1;
   logic awready, wready, bvalid, arready, rvalid, sck, cs_b;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] lane_in, lane_out, lane_oe, drv, oe_r, oe_h;
   int num_errors = 0;
   int n_tests = 0;
   // arbitrary value
   localparam logic [63:0] UID = 64'h1122_3344_5566_7788;
   always #5 core_clk = ~core_clk;
   assign lane_in = (lane_oe & lane_out) | (~lane_oe & drv);
   serial_flash_pin_interface #(.PAGE_COUNT(8192), .UNIQUE_ID(UID)) serial_flash_pin_interface_i (
      .core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck(sck), .cs_b(cs_b),
      .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe));
   spi_host spi_host_i (.sck(sck), .cs_b(cs_b), .drv(drv), .pin(lane_in), .oe(lane_oe), .wp_b(wp_b));
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tmo(input int k);
      if (k >= 60) begin
         num_errors++;
         $display("Error at %0t: bus answer missing", $time);
         give_verdict();
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         k++;
      end while (!bvalid && k < 60);
      resp = bresp;
      bready <= 0;
      tmo(k);
   endtask
   task automatic axr(input logic [7:0] a);
      int k;
      k = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge core_clk);
         if (arready) arvalid <= 0;
         k++;
      end while (!rvalid && k < 60);
      v = rdata;
      resp = rresp;
      rready <= 0;
      tmo(k);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      axr(a);
      chk(v & m, exp);
   endtask
   // the pin passes two sync flops, so let it settle before relying on it
   task automatic setwp(input logic x);
      wp_b <= x;
      repeat (6) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #300000;
      num_errors++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      rst_b <= 1;
      rchk(8'h00, 32'hFFFF, 32'h0);
      rchk(8'h04, 32'hFF, 32'hFF);
      rchk(8'h10, 32'hFFFF_FFFF, UID[31:0]);
      rchk(8'h14, 32'hFFFF_FFFF, UID[63:32]);
      rchk(8'h18, 32'hFFFF, 32'd8192);
      rchk(8'h18, 32'hFFFF_0000, {16'(serial_flash_pkg::SECTOR_PAGES), 16'h0000});
      axw(8'h00, 32'h3000);
      rchk(8'h18, 32'hFFFF_0000, {16'd8192, 16'h0000});
      axr(8'h1C);
      chk(v, 32'h0);
      chk(resp, serial_flash_pkg::RESP_SLVERR);
      axw(8'h08, 32'h1);
      chk(resp, serial_flash_pkg::RESP_SLVERR);
      chk(lane_oe, 32'h0);
      // single lane input, then a fresh select must restart decoding
      spi_host_i.frame(8'hA5, 8'h3C, 0, rd, oe_r, oe_h);
      rchk(8'h08, 32'hFFFF_0000, 32'h3CA5_0000);
      rchk(8'h0C, 32'hFFFF, 32'h1);
      spi_host_i.frame(8'h5A, 8'hC3, 0, rd, oe_r, oe_h);
      rchk(8'h08, 32'hFFFF_0000, 32'hC35A_0000);
      rchk(8'h0C, 32'hFFFF, 32'h1);
      chk(lane_oe, 32'h0);
      // single lane output with a pause in mid-byte
      axw(8'h04, 32'h96);
      axw(8'h00, 32'h800);
      spi_host_i.frame(8'h0B, 8'hFF, 1, rd, oe_r, oe_h);
      chk(rd, 8'h96);
      chk(oe_r, 4'h2);
      chk(oe_h, 4'h0);
      // dual output: lane 1 carries bits 7, 5, 3, 1 of each byte, two bytes per eight clocks
      axw(8'h00, 32'h802);
      spi_host_i.frame(8'h3B, 8'hFF, 0, rd, oe_r, oe_h);
      chk(oe_r, 4'h3);
      chk(rd, 8'h99);
      // serial number shifted out msb byte first
      axw(8'h00, 32'h808);
      spi_host_i.frame(8'h4B, 8'hFF, 0, rd, oe_r, oe_h);
      chk(rd, UID[63:56]);
      // quad with and without the enable; pause has no effect in quad
      axw(8'h00, 32'h807);
      spi_host_i.frame(8'hEB, 8'hFF, 1, rd, oe_r, oe_h);
      chk(oe_r, 4'hF);
      chk(oe_h, 4'hF);
      axw(8'h00, 32'h806);
      spi_host_i.frame(8'hEB, 8'hFF, 0, rd, oe_r, oe_h);
      chk(oe_r, 4'h2);
      // write protect pin with the lock bit, then overridden by quad enable
      axw(8'h00, 32'h10);
      setwp(0);
      axw(8'h00, 32'h11);
      rchk(8'h00, 32'hFFFF, 32'h10);
      rchk(8'h08, 32'h800, 32'h800);
      setwp(1);
      axw(8'h00, 32'h11);
      rchk(8'h00, 32'hFFFF, 32'h11);
      setwp(0);
      rchk(8'h08, 32'h800, 32'h0);
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
